// File: phy_interrupt_status_logic.sv
// Event status register, mask gating, jabber timer and elastic buffer watch of the transceiver
`timescale 1ns/1ns
`include "phy_irq_cfg.svh"

// What this block does
// - Status register shows which events occurred, whether or not their mask bit let them drive the management interrupt pin
// - Reading the status register clears every bit
// - Bit 15 sets when the carrier integrity monitor reports instability
// - Bit 14 sets on any link state change
// - Bit 13 sets on descrambler lock gained or lost
// - Bit 12 sets on two idles inside a 100 Mb/s frame
// - Bit 11 sets when the link loss counter top bit becomes one
// - Bit 10 sets when the false carrier counter top bit becomes one
// - Bit 9 sets when the receive error counter top bit becomes one
// - Bit 8 sets on elastic buffer overrun or underrun; frame is aborted
// - Elastic buffer is ten bits deep
// - Bit 7 sets when calibration completes
// - Ten-megabit transmission beyond 105 ms is cut off and sets bit 6
// - Jabber flag holds until read here, basic status read, or reset
// - No jabber detection in 100 Mb/s operation
// - Bit 5 sets when auto-negotiation completes
// - Bit 4 sets on parallel detection fault
// - Bit 3 sets when parallel detection finds an unadvertised technology
// - Auto-negotiation on: bit 2 sets on partner remote fault bit
// - Auto-negotiation off: bit 2 sets on 100 Mb/s far-end fault
// - Bit 1 sets on each verified received page
// - Mask bit set lets its event drive the pin
// - Compatibility mode disables mask bits and ignores their writes
module phy_interrupt_status_logic
  import phy_irq_pkg::*;
#(
  parameter int unsigned JABBER_CYCLES = `JABBER_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DATA_W-1:0] reg_rdata,
  input wire phy_events_t events,
  input wire logic compat_mode,
  input wire logic basic_status_rd,
  output logic irq_q,
  output logic jabber_flag_q,
  output logic tx_cutoff_q,
  output logic frame_abort_q
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [`DATA_W-1:0] status_q;
  logic [`DATA_W-1:0] status_d;
  logic [`DATA_W-1:0] set_ev;
  logic [`DATA_W-1:0] mask_q;
  logic [`DATA_W-1:0] mask_eff;
  logic [`DATA_W-1:0] rdata_q;
  logic status_rd;
  logic link_up_q;
  logic descr_q;
  logic ll_msb_q;
  logic fc_msb_q;
  logic re_msb_q;
  logic calib_q;
  logic an_done_q;
  logic lp_rf_q;
  logic [3:0] eb_fill_q;
  logic eb_fault;
  logic [21:0] jab_cnt_q;
  logic jab_trip;
  jabber_state_t jab_state_q;

  assign reg_rdata = rdata_q;
  assign status_rd = reg_rd && (reg_addr == `OFS_EVENT_CAUSE_STATUS);

  // ----------------------------------------
  // Edge history of level sources
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_up_q <= 1'b0;
      descr_q <= 1'b0;
      ll_msb_q <= 1'b0;
      fc_msb_q <= 1'b0;
      re_msb_q <= 1'b0;
      calib_q <= 1'b0;
      an_done_q <= 1'b0;
      lp_rf_q <= 1'b0;
    end else begin
      link_up_q <= events.link_up;
      descr_q <= events.descr_locked;
      ll_msb_q <= events.link_loss_msb;
      fc_msb_q <= events.false_carrier_msb;
      re_msb_q <= events.rx_error_msb;
      calib_q <= events.calib_done;
      an_done_q <= events.an_complete;
      lp_rf_q <= events.lp_remote_fault;
    end
  end

  // ----------------------------------------
  // Elastic buffer occupancy watch
  // ----------------------------------------
  // Only the fill level is tracked; the data path lives with the receive clocks
  assign eb_fault = (events.eb_push && !events.eb_pop && eb_fill_q == `ELASTIC_DEPTH) ||
                    (events.eb_pop && !events.eb_push && eb_fill_q == 4'h0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eb_fill_q <= 4'h0;
    end else if (eb_fault) begin
      eb_fill_q <= eb_fill_q;
    end else if (events.eb_push && !events.eb_pop) begin
      eb_fill_q <= eb_fill_q + 4'h1;
    end else if (events.eb_pop && !events.eb_push) begin
      eb_fill_q <= eb_fill_q - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frame_abort_q <= 1'b0;
    end else begin
      frame_abort_q <= eb_fault;
    end
  end

  // ----------------------------------------
  // Jabber timer
  // ----------------------------------------
  assign jab_trip = (jab_state_q == JAB_TIMING) && (jab_cnt_q == 22'(JABBER_CYCLES - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      jab_state_q <= JAB_IDLE;
      jab_cnt_q <= 22'h0;
    end else begin
      unique case (jab_state_q)
        JAB_IDLE: begin
          jab_cnt_q <= 22'h0;
          if (events.tx_active && events.mode_10) begin
            jab_state_q <= JAB_TIMING;
          end
        end
        JAB_TIMING: begin
          jab_cnt_q <= jab_cnt_q + 22'h1;
          if (!events.tx_active || !events.mode_10) begin
            jab_state_q <= JAB_IDLE;
          end else if (jab_trip) begin
            jab_state_q <= JAB_CUT;
          end
        end
        JAB_CUT: begin
          // Cut-off holds until the MAC drops its transmit request
          jab_cnt_q <= 22'h0;
          if (!events.tx_active) begin
            jab_state_q <= JAB_IDLE;
          end
        end
        default: begin
          jab_state_q <= JAB_IDLE;
          jab_cnt_q <= 22'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_cutoff_q <= 1'b0;
    end else begin
      tx_cutoff_q <= jab_trip || (jab_state_q == JAB_CUT && events.tx_active);
    end
  end

  // Shared with the basic status register; either read clears, a new trip wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      jabber_flag_q <= 1'b0;
    end else if (jab_trip) begin
      jabber_flag_q <= 1'b1;
    end else if (status_rd || basic_status_rd) begin
      jabber_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Event collection
  // ----------------------------------------
  always_comb begin
    set_ev = 16'h0000;
    set_ev[`BIT_CARRIER_UNSTABLE] = events.carrier_unstable;
    set_ev[`BIT_LINK_CHANGE] = events.link_up ^ link_up_q;
    set_ev[`BIT_DESCR_CHANGE] = events.descr_locked ^ descr_q;
    set_ev[`BIT_PREMATURE_END] = events.speed_100 && events.idle_pair_in_frame;
    set_ev[`BIT_LINK_LOSS_MSB] = events.link_loss_msb && !ll_msb_q;
    set_ev[`BIT_FALSE_CARRIER_MSB] = events.false_carrier_msb && !fc_msb_q;
    set_ev[`BIT_RX_ERROR_MSB] = events.rx_error_msb && !re_msb_q;
    set_ev[`BIT_ELASTIC_FAULT] = eb_fault;
    set_ev[`BIT_RESET_COMPLETE] = events.calib_done && !calib_q;
    set_ev[`BIT_JABBER] = jab_trip;
    set_ev[`BIT_AN_COMPLETE] = events.an_complete && !an_done_q;
    set_ev[`BIT_PAR_DET_FAULT] = events.par_det_fault;
    set_ev[`BIT_PAR_FAIL] = events.par_fail;
    set_ev[`BIT_REMOTE_FAULT] = events.an_enable ? (events.lp_remote_fault && !lp_rf_q)
                                                 : (events.speed_100 && events.far_end_fault);
    set_ev[`BIT_PAGE_RX] = events.page_rx;
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  // Set beats clear so an event in the read cycle shows on the next read
  always_comb begin
    status_d = status_q;
    if (status_rd) begin
      status_d = 16'h0000;
    end
    // Bit 6 is the same latch the basic status register shows, so its read clears it too
    if (basic_status_rd) begin
      status_d[`BIT_JABBER] = 1'b0;
    end
    status_d = status_d | set_ev;
    status_d[`BIT_RESERVED] = 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= `STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------
  // Mask register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= `MASK_RST;
    end else if (reg_wr && reg_addr == `OFS_EVENT_MASK && !compat_mode) begin
      mask_q <= reg_wdata & 16'hfffe;
    end
  end

  assign mask_eff = compat_mode ? 16'h0000 : mask_q;

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_eff);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
    end else if (status_rd) begin
      rdata_q <= status_q;
    end else if (reg_rd && reg_addr == `OFS_EVENT_MASK) begin
      rdata_q <= mask_eff;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_read_clears;
    status_rd && set_ev == 16'h0000 |=> status_q == 16'h0000;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

  property p_set_wins;
    status_rd && set_ev[`BIT_PAGE_RX] |=> status_q[`BIT_PAGE_RX];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost during read");

  property p_link_change;
    $changed(events.link_up) |=> status_q[`BIT_LINK_CHANGE];
  endproperty
  a_link_change: assert property (p_link_change) else $error("link change not flagged");

  property p_premature_gate;
    events.idle_pair_in_frame && !events.speed_100 && !status_q[`BIT_PREMATURE_END]
      |=> !status_q[`BIT_PREMATURE_END];
  endproperty
  a_premature_gate: assert property (p_premature_gate) else $error("premature end outside 100 Mb/s");

  property p_irq_follows;
    |(status_q & mask_eff) |=> irq_q;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("pin not raised for enabled event");

  property p_irq_compat;
    compat_mode ##1 compat_mode |-> !irq_q;
  endproperty
  a_irq_compat: assert property (p_irq_compat) else $error("pin raised in compatibility mode");

  property p_bit0_zero;
    ##1 reg_rdata[`BIT_RESERVED] == 1'b0 && status_q[`BIT_RESERVED] == 1'b0;
  endproperty
  a_bit0_zero: assert property (p_bit0_zero) else $error("reserved bit set");

  property p_jabber_latch;
    jab_trip |=> jabber_flag_q && status_q[`BIT_JABBER] && tx_cutoff_q;
  endproperty
  a_jabber_latch: assert property (p_jabber_latch) else $error("jabber trip not latched");

  property p_basic_clear;
    basic_status_rd && !jab_trip |=> !jabber_flag_q && !status_q[`BIT_JABBER];
  endproperty
  a_basic_clear: assert property (p_basic_clear) else $error("jabber not cleared by basic status read");

  property p_no_jabber_100;
    !events.mode_10 [*2] |-> jab_state_q != JAB_TIMING;
  endproperty
  a_no_jabber_100: assert property (p_no_jabber_100) else $error("jabber timing outside 10BASE-T");

  property p_eb_abort;
    eb_fault |=> frame_abort_q && status_q[`BIT_ELASTIC_FAULT];
  endproperty
  a_eb_abort: assert property (p_eb_abort) else $error("elastic fault not reported");

  property p_rdata_status;
    status_rd |=> reg_rdata == $past(status_q);
  endproperty
  a_rdata_status: assert property (p_rdata_status) else $error("status read data wrong");

  c_read_clear: cover property (status_q != 16'h0000 ##0 status_rd ##1 status_q == 16'h0000);
  c_jabber: cover property (jab_trip);
  c_irq: cover property (!irq_q ##1 irq_q);
  c_eb_fault: cover property (eb_fault);

endmodule

// File: phy_irq_cfg.svh
// Register offsets, field positions, reset values and timing counts of the event status block
`ifndef PHY_IRQ_CFG_SVH
`define PHY_IRQ_CFG_SVH

`define ADDR_W 5
`define DATA_W 16
`define OFS_EVENT_MASK 5'h10
`define OFS_EVENT_CAUSE_STATUS 5'h11

`define BIT_CARRIER_UNSTABLE 15
`define BIT_LINK_CHANGE 14
`define BIT_DESCR_CHANGE 13
`define BIT_PREMATURE_END 12
`define BIT_LINK_LOSS_MSB 11
`define BIT_FALSE_CARRIER_MSB 10
`define BIT_RX_ERROR_MSB 9
`define BIT_ELASTIC_FAULT 8
`define BIT_RESET_COMPLETE 7
`define BIT_JABBER 6
`define BIT_AN_COMPLETE 5
`define BIT_PAR_DET_FAULT 4
`define BIT_PAR_FAIL 3
`define BIT_REMOTE_FAULT 2
`define BIT_PAGE_RX 1
`define BIT_RESERVED 0

`define STATUS_RST 16'h0000
`define MASK_RST 16'h4080

`define ELASTIC_DEPTH 4'ha
`define CLK_HZ 20000000
`define JABBER_MS 105
`define JABBER_CYC ((`JABBER_MS * `CLK_HZ) / 1000)

`endif

// File: phy_irq_pkg.sv
// Types shared by the event status block
package phy_irq_pkg;

  // Event sources, all from logic on the same clock
  typedef struct packed {
    logic carrier_unstable;
    logic link_up;
    logic descr_locked;
    logic speed_100;
    logic idle_pair_in_frame;
    logic link_loss_msb;
    logic false_carrier_msb;
    logic rx_error_msb;
    logic eb_push;
    logic eb_pop;
    logic calib_done;
    logic mode_10;
    logic tx_active;
    logic an_complete;
    logic an_enable;
    logic par_det_fault;
    logic par_fail;
    logic lp_remote_fault;
    logic far_end_fault;
    logic page_rx;
  } phy_events_t;

  typedef enum logic [1:0] {
    JAB_IDLE = 2'b00,
    JAB_TIMING = 2'b01,
    JAB_CUT = 2'b10
  } jabber_state_t;

endpackage

// File: sta_master.sv
// Station management model that drives the register port
`timescale 1ns/1ns
`include "phy_irq_cfg.svh"
module sta_master (
  input wire logic clk,
  output logic [`ADDR_W-1:0] reg_addr,
  output logic [`DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [`DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle bus shows the inverse, so a stale value is never taken for a live one
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// File: tb.sv
// Self-checking bench for the event status block
`timescale 1ns/1ns
`include "phy_irq_cfg.svh"
module tb;
  import phy_irq_pkg::*;
  localparam int JC = 20;
  logic clk;
  logic rstn;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  phy_events_t ev;
  logic compat_mode;
  logic basic_status_rd;
  logic irq_q;
  logic jabber_flag_q;
  logic tx_cutoff_q;
  logic frame_abort_q;
  logic [15:0] rv;
  int n_errors;
  int check_count;
  int k;
  int n;
  // Rows: event pattern for one cycle, then the status word it must leave
  logic [35:0] rows [18] = '{
    {20'h80000, 16'h8000}, {20'h40000, 16'h4000},
    {20'h20000, 16'h2000}, {20'h18000, 16'h1000},
    {20'h08000, 16'h0000}, {20'h04000, 16'h0800},
    {20'h02000, 16'h0400}, {20'h01000, 16'h0200},
    {20'h00400, 16'h0100}, {20'h00200, 16'h0080},
    {20'h00040, 16'h0020}, {20'h00010, 16'h0010},
    {20'h00008, 16'h0008}, {20'h00024, 16'h0004},
    {20'h00004, 16'h0000}, {20'h10002, 16'h0004},
    {20'h10022, 16'h0000}, {20'h00001, 16'h0002}};

  phy_interrupt_status_logic #(.JABBER_CYCLES(JC)) u_phy_interrupt_status_logic (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .events(ev), .compat_mode(compat_mode), .basic_status_rd(basic_status_rd), .irq_q(irq_q),
    .jabber_flag_q(jabber_flag_q), .tx_cutoff_q(tx_cutoff_q), .frame_abort_q(frame_abort_q));
  sta_master u_sta_master (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ------
  // Helpers
  // ------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic hold(input logic [19:0] v, input int c);
    @(posedge clk);
    ev <= v;
    repeat (c) @(posedge clk);
    ev <= '0;
  endtask
  task automatic stat(input logic [15:0] exp);
    u_sta_master.rd(`OFS_EVENT_CAUSE_STATUS, rv);
    chk(rv, exp);
  endtask
  task automatic results();
    $display("Mismatches %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2ms;
    n_errors++;
    results();
  end

  // ------
  // Sequence
  // ------
  initial begin
    rstn = 1'b0;
    ev = '0;
    compat_mode = 1'b0;
    basic_status_rd = 1'b0;
    n_errors = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    u_sta_master.wr(`OFS_EVENT_MASK, 16'hffff);
    for (k = 0; k < 18; k++) begin
      hold(rows[k][35:16], 1);
      step(1);
      chk({15'h0, irq_q}, {15'h0, rows[k][15:0] != 16'h0});
      stat(rows[k][15:0]);
      stat(16'h0000);
      chk({15'h0, irq_q}, 16'h0000);
    end
    // Only page received let through to the pin
    u_sta_master.wr(`OFS_EVENT_MASK, 16'h0002);
    hold(20'h00008, 1);
    step(1);
    chk({15'h0, irq_q}, 16'h0000);
    hold(20'h00001, 1);
    step(1);
    chk({15'h0, irq_q}, 16'h0001);
    stat(16'h000a);
    @(posedge clk);
    compat_mode <= 1'b1;
    u_sta_master.wr(`OFS_EVENT_MASK, 16'hffff);
    hold(20'h00001, 1);
    step(1);
    chk({15'h0, irq_q}, 16'h0000);
    @(posedge clk);
    compat_mode <= 1'b0;
    u_sta_master.rd(`OFS_EVENT_MASK, rv);
    chk(rv, 16'h0002);
    stat(16'h0002);
    u_sta_master.wr(`OFS_EVENT_MASK, 16'hffff);
    u_sta_master.wr(`OFS_EVENT_CAUSE_STATUS, 16'hffff);
    u_sta_master.rd(`OFS_EVENT_MASK, rv);
    chk(rv, 16'hfffe);
    stat(16'h0000);
    u_sta_master.rd(5'h1f, rv);
    chk(rv, 16'h0000);
    // Ten pushes fit; the eleventh overruns and aborts exactly one frame
    hold(20'h00800, 10);
    stat(16'h0000);
    hold(20'h00800, 1);
    n = 0;
    for (k = 0; k < 3; k++) begin
      #1;
      if (frame_abort_q === 1'b1) n++;
      @(posedge clk);
    end
    chk(n[15:0], 16'h0001);
    stat(16'h0100);
    hold(20'h00400, 10);
    stat(16'h0000);
    // Jabber must not trip before the full count
    @(posedge clk);
    ev <= 20'h00180;
    step(JC);
    chk({14'h0, tx_cutoff_q, jabber_flag_q}, 16'h0000);
    n = 0;
    while (tx_cutoff_q !== 1'b1 && n < 4) begin
      step(1);
      n++;
    end
    chk({14'h0, tx_cutoff_q, jabber_flag_q}, 16'h0003);
    chk(n[15:0], 16'h0001);
    @(posedge clk);
    ev <= '0;
    step(2);
    chk({14'h0, tx_cutoff_q, jabber_flag_q}, 16'h0001);
    stat(16'h0040);
    chk({15'h0, jabber_flag_q}, 16'h0000);
    hold(20'h00180, JC + 4);
    step(1);
    chk({15'h0, jabber_flag_q}, 16'h0001);
    @(posedge clk);
    basic_status_rd <= 1'b1;
    @(posedge clk);
    basic_status_rd <= 1'b0;
    step(1);
    chk({15'h0, jabber_flag_q}, 16'h0000);
    stat(16'h0000);
    hold(20'h00080, JC + 4);
    #1;
    chk({14'h0, tx_cutoff_q, jabber_flag_q}, 16'h0000);
    stat(16'h0000);
    // Reset in mid-run with a bit pending
    hold(20'h00001, 1);
    @(posedge clk);
    rstn <= 1'b0;
    step(2);
    chk({13'h0, irq_q, tx_cutoff_q, jabber_flag_q}, 16'h0000);
    @(posedge clk);
    rstn <= 1'b1;
    u_sta_master.rd(`OFS_EVENT_MASK, rv);
    chk(rv, 16'h4080);
    stat(16'h0000);
    results();
  end
endmodule
